// ### rtl/acq_regs.vh
`ifndef ACQ_REGS_VH
`define ACQ_REGS_VH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_RES_FIRST 8'h04
`define OFS_RES_LAST 8'h20
`define OFS_FLAGS 8'h24
`define OFS_ENABLE 8'h40
`define OFS_RANGE 8'h44
`define OFS_FUNC 8'h48
`define OFS_MEAN 8'h4C
`define OFS_SCALE 8'h50
`define OFS_LIMIT 8'h54
`define OFS_UNIT 8'h58
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define FUNC_BCD_BIT 16
`define UNIT_RUN_BIT 4
`define UNIT_RESTART_BIT 5
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_ENABLE 8'hFF
`define RST_LIMIT_LO 16'h8000
`define RST_LIMIT_HI 16'h7FFF
`define RST_UNIT 4'h0
// ------------------------------------------------------------
// Input ranges and codes
// ------------------------------------------------------------
`define RNG_0_10V 2'h0
`define RNG_1_5V 2'h1
`define RNG_4_20MA 2'h2
`define RNG_BIPOLAR 2'h3
`define CODE_FULL 12'hFA0
`define CODE_MID 12'h7D0
`define SCALE_RECIP 41'h0000000418A
`define SCALE_SHIFT 26
// ------------------------------------------------------------
// Word bank numbering
// ------------------------------------------------------------
`define REFRESH_BASE 10'h064
`define REFRESH_EXT_BASE 10'h190
`define SETUP_BASE 12'h3E8
`define UNIT_EXT_FIRST 4'hA
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BOOT_WAIT 2'h3
`endif

// ### rtl/eight_input_analog_acquisition.v
// What this block does
// R1 - Run lamp lit when healthy; fault halts operation
// R2 - Wire-fault lamp only for 1-5 V, 4-20 mA
// R3 - Disabled inputs skipped, scan visits enabled ones
// R4 - Each input holds its own range selection
// R5 - Results encoded BCD or binary per setting
// R6 - Square root option linearises quadratic inputs
// R7 - Scaling maps value linearly, result in BCD
// R8 - Mean drops one minimum, one maximum, averages
// R9 - Peak mode holds largest output value seen
// R10 - Warning flag when outside upper/lower limit
// R11 - Open wire sets per-input disconnection flag, which lights wire_fault_lamp
// R12 - Unit switch selects refresh and setup banks
// R13 - Unit number defaults to zero
// R14 - Host refuses duplicate unit numbers
// R15 - Switch sampled only at power-up or restart
// R16 - Units 10-15 need compatible host, upper bank
// R17 - Ten host words exchanged every refresh
// R18 - Bipolar sign in bit 15, none when scaled/rooted
// R19 - Unipolar spans 0000-0FA0 binary, 0000-4000 BCD
// R20 - Result word written only when fully processed
`timescale 1ns/1ps
`default_nettype none
`include "acq_regs.vh"
module eight_input_analog_acquisition (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Converter
  output wire adc_start,
  output wire [2:0] adc_chan,
  input wire adc_done,
  input wire [11:0] adc_code,
  // Pins
  input wire [7:0] wire_open,
  input wire [3:0] unit_select_switch,
  input wire host_ext_capable,
  output wire run_lamp,
  output wire wire_fault_lamp
);
  localparam S_IDLE = 4'h1;
  localparam S_CONV = 4'h2;
  localparam S_ROOT = 4'h4;
  localparam S_PROC = 4'h8;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [12:0] meta_q;
  reg [12:0] sync_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 13'h0000;
      sync_q <= 13'h0000;
    end else begin
      meta_q <= {host_ext_capable, unit_select_switch, wire_open};
      sync_q <= meta_q;
    end
  end
  wire [7:0] open_s = sync_q[7:0];
  wire [3:0] sw_s = sync_q[11:8];
  wire ext_ok_s = sync_q[12];

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  reg [7:0] peak_en_q, enable_q, warn_q, disc_q;
  reg [15:0] range_q;
  reg [16:0] func_q;
  reg [9:0] mean_q;
  reg [13:0] sc_lo_q, sc_hi_q;
  reg signed [15:0] lim_lo_q, lim_hi_q;
  reg [3:0] unit_q;
  reg [1:0] boot_q;
  reg restart_q, restart_prev_q;
  reg pready_q, pslverr_q, run_q, lamp_q, adc_start_q;
  reg [31:0] prdata_q;
  reg [3:0] state_q;
  reg [2:0] ch_q;
  reg [11:0] u_q;
  reg signed [17:0] sum_q [0:7];
  reg signed [15:0] min_q [0:7];
  reg signed [15:0] max_q [0:7];
  reg signed [15:0] peak_q [0:7];
  reg [3:0] cnt_q [0:7];
  integer i;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign adc_start = adc_start_q;
  assign adc_chan = ch_q;
  assign run_lamp = run_q;
  assign wire_fault_lamp = lamp_q;

  // ------------------------------------------------------------
  // Unit number and run state
  // ------------------------------------------------------------
  wire take_unit = (boot_q == 2'h1) | (restart_prev_q & ~restart_q); // R15
  wire ext_unit = (unit_q >= `UNIT_EXT_FIRST);
  wire ext_err = ext_unit & ~ext_ok_s; // R16
  wire run = ~ext_err & ~restart_q & (boot_q == 2'h0); // R1
  wire [9:0] refresh_base = ext_unit ? // R16
    `REFRESH_EXT_BASE + 10'd10 * {6'h00, unit_q - `UNIT_EXT_FIRST} :
    `REFRESH_BASE + 10'd10 * {6'h00, unit_q}; // R12
  wire [11:0] setup_base = `SETUP_BASE + 12'd100 * {8'h00, unit_q}; // R12

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [2:0] next_ch;
    input [2:0] c;
    input [7:0] en;
    integer j;
    reg [2:0] k;
    reg f;
    begin
      next_ch = c;
      f = 1'b0;
      for (j = 1; j <= 8; j = j + 1) begin
        k = c + j[2:0];
        if (!f && en[k]) begin
          next_ch = k;
          f = 1'b1;
        end
      end
    end
  endfunction

  function [15:0] to_bcd;
    input [13:0] b;
    integer j;
    reg [29:0] s;
    begin
      s = {16'h0000, b};
      for (j = 0; j < 14; j = j + 1) begin
        if (s[17:14] > 4'h4) s[17:14] = s[17:14] + 4'h3;
        if (s[21:18] > 4'h4) s[21:18] = s[21:18] + 4'h3;
        if (s[25:22] > 4'h4) s[25:22] = s[25:22] + 4'h3;
        if (s[29:26] > 4'h4) s[29:26] = s[29:26] + 4'h3;
        s = {s[28:0], 1'b0};
      end
      to_bcd = s[29:14];
    end
  endfunction

  // ------------------------------------------------------------
  // Sample processing
  // ------------------------------------------------------------
  wire [11:0] code_c = (adc_code > `CODE_FULL) ? `CODE_FULL : adc_code;
  wire [1:0] rng = range_q[2*ch_q +: 2]; // R4
  wire bip = (rng == `RNG_BIPOLAR);
  wire do_sqrt = func_q[ch_q];
  wire do_scale = func_q[8+ch_q];
  wire do_mean = mean_q[ch_q];
  wire [1:0] mk = (mean_q[9:8] == 2'h0) ? 2'h1 : mean_q[9:8];
  wire [3:0] mean_n = (4'h1 << mk) + 4'h2;
  wire [13:0] span = (sc_hi_q > sc_lo_q) ? sc_hi_q - sc_lo_q : 14'h0000;
  wire [25:0] p1 = u_q * span;
  wire [40:0] p2 = {15'h0000, p1} * `SCALE_RECIP;
  wire sq_done;
  wire [11:0] sq_root;

  reg signed [15:0] sv, mn, mx, mv, pv, mag;
  reg signed [17:0] sum_n, dif, dsh;
  reg [15:0] word;
  reg mean_done, wr, nosign;
  always @* begin
    if (do_scale) begin
      sv = $signed({2'b00, sc_lo_q}) + $signed({1'b0, p2[40:26]}); // R7
    end else if (bip && !do_sqrt) begin
      sv = $signed({4'h0, u_q}) - $signed({4'h0, `CODE_MID});
    end else begin
      sv = $signed({4'h0, u_q}); // R6
    end
    sum_n = sum_q[ch_q] + {{2{sv[15]}}, sv};
    mn = (cnt_q[ch_q] == 4'h0 || sv < min_q[ch_q]) ? sv : min_q[ch_q];
    mx = (cnt_q[ch_q] == 4'h0 || sv > max_q[ch_q]) ? sv : max_q[ch_q];
    dif = sum_n - {{2{mn[15]}}, mn} - {{2{mx[15]}}, mx}; // R8
    mean_done = (cnt_q[ch_q] + 4'h1 == mean_n);
    dsh = dif >>> mk;
    mv = do_mean ? dsh[15:0] : sv;
    wr = (state_q == S_PROC) && (!do_mean || mean_done); // R20
    pv = (peak_en_q[ch_q] && peak_q[ch_q] > mv) ? peak_q[ch_q] : mv; // R9
    nosign = do_scale | do_sqrt | ~bip; // R18
    mag = (pv < 0) ? -pv : pv;
    if (do_scale || func_q[`FUNC_BCD_BIT]) begin
      word = to_bcd(mag[13:0]); // R5 R19
    end else begin
      word = mag; // R19
    end
    if (!nosign && pv < 0) begin
      word[15] = 1'b1; // R18
    end
  end

  sqrt_unit #(
    .W(24)
  ) u_sqrt (
    .clk(pclk),
    .rst_n(presetn),
    .start(state_q == S_CONV && adc_done && do_sqrt),
    .radicand({12'h000, code_c} * {12'h000, `CODE_FULL}), // R6
    .done_q(sq_done),
    .root_q(sq_root)
  );

  // ------------------------------------------------------------
  // Scan sequencer
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      ch_q <= 3'h7;
      u_q <= 12'h000;
      adc_start_q <= 1'b0;
      warn_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        sum_q[i] <= 18'h00000;
        min_q[i] <= 16'h0000;
        max_q[i] <= 16'h0000;
        peak_q[i] <= 16'h0000;
        cnt_q[i] <= 4'h0;
      end
    end else begin
      adc_start_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (run && enable_q != 8'h00) begin // R1
            ch_q <= next_ch(ch_q, enable_q); // R3
            adc_start_q <= 1'b1;
            state_q <= S_CONV;
          end
        end
        S_CONV: begin
          if (!run) begin
            state_q <= S_IDLE; // R1
          end else if (adc_done) begin
            u_q <= code_c;
            state_q <= do_sqrt ? S_ROOT : S_PROC;
          end
        end
        S_ROOT: begin
          if (sq_done) begin
            u_q <= sq_root;
            state_q <= S_PROC;
          end
        end
        S_PROC: begin
          if (do_mean) begin
            sum_q[ch_q] <= mean_done ? 18'h00000 : sum_n; // R8
            min_q[ch_q] <= mn;
            max_q[ch_q] <= mx;
            cnt_q[ch_q] <= mean_done ? 4'h0 : cnt_q[ch_q] + 4'h1;
          end
          if (wr) begin
            peak_q[ch_q] <= pv; // R9
            warn_q[ch_q] <= (pv > lim_hi_q) || (pv < lim_lo_q); // R10
          end
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  wire [15:0] res_rd;
  result_mem #(
    .WIDTH(16),
    .AW(3)
  ) u_res (
    .clk(pclk),
    .we(wr),
    .waddr(ch_q),
    .wdata(word),
    .raddr(paddr[4:2] - 3'h1),
    .rdata_q(res_rd)
  );

  // ------------------------------------------------------------
  // Lamps and wire checks
  // ------------------------------------------------------------
  reg [7:0] live;
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      live[i] = (range_q[2*i +: 2] == `RNG_1_5V) || (range_q[2*i +: 2] == `RNG_4_20MA);
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_q <= 8'h00;
      lamp_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      disc_q <= open_s & live & enable_q; // R11 R2
      lamp_q <= |disc_q; // R2
      run_q <= run; // R1
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // One wait state on every transfer so the result memory can answer
  wire acc = psel & penable;
  wire wen = acc & pready_q & pwrite;
  wire is_res = (paddr >= `OFS_RES_FIRST) && (paddr <= `OFS_RES_LAST);
  reg [31:0] rd;
  reg bad;
  always @* begin
    rd = 32'h00000000;
    bad = 1'b0;
    case (paddr)
      `OFS_CTRL: rd = {24'h000000, peak_en_q}; // R17
      `OFS_FLAGS: rd = {16'h0000, warn_q, disc_q}; // R10 R11
      `OFS_ENABLE: rd = {24'h000000, enable_q};
      `OFS_RANGE: rd = {16'h0000, range_q};
      `OFS_FUNC: rd = {15'h0000, func_q};
      `OFS_MEAN: rd = {22'h000000, mean_q};
      `OFS_SCALE: rd = {2'h0, sc_hi_q, 2'h0, sc_lo_q};
      `OFS_LIMIT: rd = {lim_hi_q, lim_lo_q};
      `OFS_UNIT: rd = {4'h0, setup_base, refresh_base, restart_q, run, unit_q};
      default: begin
        if (is_res && paddr[1:0] == 2'h0) begin
          rd = {16'h0000, res_rd}; // R17
        end else begin
          bad = 1'b1;
        end
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      peak_en_q <= 8'h00;
      enable_q <= `RST_ENABLE;
      range_q <= 16'h0000;
      func_q <= 17'h00000;
      mean_q <= 10'h000;
      sc_lo_q <= 14'h0000;
      sc_hi_q <= 14'h0000;
      lim_lo_q <= `RST_LIMIT_LO;
      lim_hi_q <= `RST_LIMIT_HI;
      unit_q <= `RST_UNIT; // R13
      boot_q <= `BOOT_WAIT;
      restart_q <= 1'b0;
      restart_prev_q <= 1'b0;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & bad;
      prdata_q <= (acc & ~pready_q & ~pwrite) ? rd : 32'h00000000;
      restart_prev_q <= restart_q;
      if (boot_q != 2'h0) begin
        boot_q <= boot_q - 2'h1;
      end
      if (take_unit) begin
        unit_q <= sw_s; // R15 R12
      end
      if (wen) begin
        case (paddr)
          `OFS_CTRL: peak_en_q <= pwdata[7:0]; // R17
          `OFS_ENABLE: enable_q <= pwdata[7:0]; // R3
          `OFS_RANGE: range_q <= pwdata[15:0]; // R4
          `OFS_FUNC: func_q <= pwdata[16:0]; // R5
          `OFS_MEAN: mean_q <= pwdata[9:0];
          `OFS_SCALE: begin
            sc_lo_q <= pwdata[13:0];
            sc_hi_q <= pwdata[29:16];
          end
          `OFS_LIMIT: begin
            lim_lo_q <= pwdata[15:0];
            lim_hi_q <= pwdata[31:16];
          end
          `OFS_UNIT: restart_q <= pwdata[`UNIT_RESTART_BIT]; // R15
          default: ;
        endcase
      end
    end
  end
endmodule // eight_input_analog_acquisition
`default_nettype wire

// ### rtl/result_mem.v
`timescale 1ns/1ps
`default_nettype none
module result_mem #(
  parameter WIDTH = 16,
  parameter AW = 3
) (
  // Clock
  input wire clk,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata_q
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // No reset: contents undefined until the first scan writes them
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // result_mem
`default_nettype wire

// ### rtl/sqrt_unit.v
`timescale 1ns/1ps
`default_nettype none
module sqrt_unit #(
  parameter W = 24
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Request
  input wire start,
  input wire [W-1:0] radicand,
  // Answer
  output reg done_q,
  output reg [W/2-1:0] root_q
);
  reg [W-1:0] rad_q;
  reg [W/2+1:0] rem_q;
  reg [4:0] cnt_q;
  reg busy_q;
  wire [W/2+1:0] rem_sh = {rem_q[W/2-1:0], rad_q[W-1:W-2]};
  wire [W/2+1:0] trial = {root_q, 2'b01};

  // One result bit per cycle; bit-serial keeps the area small
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rad_q <= {W{1'b0}};
      rem_q <= {(W/2+2){1'b0}};
      root_q <= {(W/2){1'b0}};
      cnt_q <= 5'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rad_q <= radicand;
        rem_q <= {(W/2+2){1'b0}};
        root_q <= {(W/2){1'b0}};
        cnt_q <= W[5:1];
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rad_q <= {rad_q[W-3:0], 2'b00};
        if (rem_sh >= trial) begin
          rem_q <= rem_sh - trial;
          root_q <= {root_q[W/2-2:0], 1'b1};
        end else begin
          rem_q <= rem_sh;
          root_q <= {root_q[W/2-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // sqrt_unit
`default_nettype wire

// ### verification/acq_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "acq_regs.vh"
module acq_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter and lamps
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  input wire logic [7:0] wire_open,
  input wire logic run_lamp,
  input wire logic wire_fault_lamp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Shadow of enable and restart bits
  // ----
  logic [7:0] en_q;
  logic restart_q;
  wire wr_ok = psel && penable && pready && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= `RST_ENABLE;
      restart_q <= 1'h0;
    end else if (wr_ok && paddr == `OFS_ENABLE) begin
      en_q <= pwdata[7:0];
    end else if (wr_ok && paddr == `OFS_UNIT) begin
      restart_q <= pwdata[`UNIT_RESTART_BIT];
    end
  end
  // ----
  // Properties
  // ----
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  property p_ready_walk;
    s_setup |-> s_answer;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_unmapped;
    psel && penable && pready && paddr > `OFS_UNIT |-> pslverr;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_rd_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  property p_chan_hold;
    $past(presetn) && !adc_start |-> $stable(adc_chan);
  endproperty
  property p_start_enabled;
    adc_start |-> en_q[adc_chan];
  endproperty
  property p_lamp_clear;
    (wire_open == 8'h00) [*8] |-> !wire_fault_lamp;
  endproperty
  property p_halt;
    restart_q [*4] |-> !run_lamp;
  endproperty
  property p_boot;
    $rose(presetn) |-> ##[1:8] run_lamp;
  endproperty
  a_ready_walk: assert property (p_ready_walk) else $error("ready timing");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready width");
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
  a_err_ready: assert property (p_err_ready) else $error("lone error");
  a_rd_idle: assert property (p_rd_idle) else $error("idle data");
  a_start_pulse: assert property (p_start_pulse) else $error("start width");
  a_chan_hold: assert property (p_chan_hold) else $error("chan moved");
  a_start_enabled: assert property (p_start_enabled) else $error("disabled start");
  a_lamp_clear: assert property (p_lamp_clear) else $error("lamp stuck");
  a_halt: assert property (p_halt) else $error("run while halted");
  a_boot: assert property (p_boot) else $error("no run");
endmodule // acq_checker
`default_nettype wire

// ### verification/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Converter handshake
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  output logic adc_done,
  output logic [11:0] adc_code,
  // Bench controls
  input wire logic [95:0] codes,
  input wire logic jitter
);
  // ----
  // Conversion
  // ----
  logic busy_q;
  logic slow_q;
  logic [3:0] wait_q;
  logic [2:0] ch_q;
  logic [1:0] ph_q;
  logic [11:0] val;
  // Input 0 walks a four-step pattern so dropping min and max shows
  assign val = codes[ch_q * 12 +: 12] + ((!jitter || ch_q != 3'h0) ? 12'h000 :
    (ph_q == 2'h3) ? 12'h028 : (ph_q == 2'h0) ? 12'h000 : 12'h004);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'h0;
      slow_q <= 1'h0;
      wait_q <= 4'h0;
      ch_q <= 3'h0;
      ph_q <= 2'h0;
      adc_done <= 1'h0;
      adc_code <= 12'h000;
    end else begin
      adc_done <= 1'h0;
      // Junk between results: the last code and its inverse alternate
      adc_code <= ~adc_code;
      if (adc_start) begin
        busy_q <= 1'h1;
        ch_q <= adc_chan;
        slow_q <= ~slow_q;
        wait_q <= slow_q ? 4'h9 : 4'h0;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'h0;
        adc_done <= 1'h1;
        adc_code <= val;
        ph_q <= ph_q + ((ch_q == 3'h0) ? 2'h1 : 2'h0);
      end
    end
  end
endmodule // adc_model
`default_nettype wire

// ### verification/eight_input_analog_acquisition_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "acq_regs.vh"
module eight_input_analog_acquisition_test;
  // ----
  // Signals
  // ----
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] wire_open = 8'h00;
  logic [3:0] unit_select_switch = 4'h0;
  logic host_ext_capable = 1'h1;
  logic [7:0][11:0] codes = '0;
  logic jitter = 1'h0;
  wire [31:0] prdata;
  wire pready, pslverr, adc_start, adc_done, run_lamp, wire_fault_lamp;
  wire [2:0] adc_chan;
  wire [11:0] adc_code;
  logic [33:0] notes[$];
  logic [33:0] note;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 91;
  int i;
  eight_input_analog_acquisition i_eight_input_analog_acquisition (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_code(adc_code),
    .wire_open(wire_open), .unit_select_switch(unit_select_switch),
    .host_ext_capable(host_ext_capable), .run_lamp(run_lamp),
    .wire_fault_lamp(wire_fault_lamp));
  adc_model i_adc_model (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_done(adc_done), .adc_code(adc_code), .codes(codes),
    .jitter(jitter));
  always #2 pclk = ~pclk;
  // ----
  // Helpers
  // ----
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Note is {read, error, data}; only reads compare data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    notes.push_back({~w, e, w ? 32'h0 : d});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 1'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'h0, a, d, 1'h0);
  endtask
  task automatic starts(input int n);
    repeat (n) begin
      @(posedge pclk);
      while (adc_start !== 1'h1) @(posedge pclk);
    end
  endtask
  task automatic restart();
    wr(`OFS_UNIT, 32'h20);
    wr(`OFS_UNIT, 32'h0);
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic [7:0] res(input int c);
    return 8'(`OFS_RES_FIRST + 4 * c);
  endfunction
  function automatic logic [15:0] bcd(input int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  function automatic logic [15:0] bip(input int c, input logic b);
    int m;
    m = (c < `CODE_MID) ? `CODE_MID - c : c - `CODE_MID;
    return {1'(c < `CODE_MID), 15'(b ? 32'(bcd(m)) : m)};
  endfunction
  function automatic logic [31:0] uword(input int u, input logic run);
    logic [9:0] r;
    r = (u < 10) ? 10'(`REFRESH_BASE + 10 * u) : 10'(`REFRESH_EXT_BASE + 10 * (u - 10));
    return {4'h0, 12'(`SETUP_BASE + 100 * u), r, 1'h0, run, 4'(u)};
  endfunction
  always @(posedge pclk) begin
    if (pready === 1'h1) begin
      note = (notes.size() > 0) ? notes.pop_front() : {34{1'h1}};
      check({pslverr, note[33] ? prdata : 32'h0}, note[32:0]);
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    rd(`OFS_ENABLE, 32'h000000FF);
    rd(`OFS_LIMIT, 32'h7FFF8000);
    rd(`OFS_UNIT, uword(0, 1'h1));
    apb(1'h0, 8'h5C, 32'h0, 1'h1);
    for (i = 0; i < 8; i++) begin
      codes[i] <= 12'($unsigned($random(seed)) % 4001);
    end
    starts(24);
    for (i = 0; i < 8; i++) begin
      rd(res(i), {20'h0, codes[i]});
    end
    wr(`OFS_FUNC, 32'h00010000);
    starts(24);
    for (i = 0; i < 8; i++) begin
      rd(res(i), {16'h0, bcd(codes[i])});
    end
    wr(`OFS_RANGE, 32'h0000FFFF);
    codes[0] <= 12'h000;
    codes[1] <= 12'hFA0;
    codes[2] <= `CODE_MID;
    codes[3] <= 12'h3E8;
    for (int b = 1; b >= 0; b--) begin
      wr(`OFS_FUNC, {15'h0, 1'(b), 16'h0});
      starts(24);
      for (i = 0; i < 4; i++) begin
        rd(res(i), {16'h0, bip(codes[i], 1'(b))});
      end
    end
    wr(`OFS_RANGE, 32'h0);
    wr(`OFS_FUNC, 32'h00000003);
    codes[0] <= 12'h3E8;
    starts(24);
    rd(res(0), 32'h000007D0);
    rd(res(1), 32'h00000FA0);
    rd(res(2), 32'h000007D0);
    wr(`OFS_SCALE, 32'h270F0064);
    wr(`OFS_FUNC, 32'h00000300);
    codes[0] <= 12'h000;
    starts(24);
    rd(res(0), 32'h00000100);
    rd(res(1), 32'h00009999);
    wr(`OFS_FUNC, 32'h0);
    codes[0] <= 12'h400;
    jitter <= 1'h1;
    wr(`OFS_MEAN, 32'h00000101);
    starts(96);
    rd(res(0), 32'h00000404);
    jitter <= 1'h0;
    wr(`OFS_MEAN, 32'h0);
    codes[0] <= 12'h800;
    starts(24);
    wr(`OFS_CTRL, 32'h1);
    codes[0] <= 12'h300;
    starts(24);
    rd(res(0), 32'h00000800);
    wr(`OFS_CTRL, 32'h0);
    starts(24);
    rd(res(0), 32'h00000300);
    wr(`OFS_LIMIT, 32'h02000100);
    wr(`OFS_RANGE, 32'h00000840);
    for (i = 0; i < 8; i++) begin
      codes[i] <= (i == 0) ? 12'h050 : (i == 2) ? 12'h300 : 12'h150;
    end
    wire_open <= 8'h38;
    starts(24);
    rd(`OFS_FLAGS, 32'h00000528);
    check({32'h0, wire_fault_lamp}, 33'h1);
    wire_open <= 8'h00;
    starts(24);
    rd(`OFS_FLAGS, 32'h00000500);
    check({32'h0, wire_fault_lamp}, 33'h0);
    wr(`OFS_LIMIT, 32'h7FFF8000);
    wr(`OFS_UNIT, 32'h20);
    repeat (40) @(posedge pclk);
    check({32'h0, run_lamp}, 33'h0);
    wr(`OFS_ENABLE, 32'h05);
    wr(`OFS_UNIT, 32'h0);
    for (i = 0; i < 16; i++) begin
      starts(1);
      check({32'h0, adc_chan[0] | adc_chan[2]}, 33'h0);
    end
    for (i = 0; i < 16; i++) begin
      unit_select_switch <= 4'(i);
      repeat (4) @(posedge pclk);
      rd(`OFS_UNIT, uword((i == 0) ? 0 : i - 1, 1'h1));
      restart();
      rd(`OFS_UNIT, uword(i, 1'h1));
    end
    host_ext_capable <= 1'h0;
    unit_select_switch <= 4'hC;
    repeat (4) @(posedge pclk);
    restart();
    rd(`OFS_UNIT, uword(12, 1'h0));
    check({32'h0, run_lamp}, 33'h0);
    end_sim();
  end
endmodule // eight_input_analog_acquisition_test
bind eight_input_analog_acquisition acq_checker i_acq_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_start(adc_start), .adc_chan(adc_chan), .wire_open(wire_open),
  .run_lamp(run_lamp), .wire_fault_lamp(wire_fault_lamp));
`default_nettype wire
